//--- fpc_params.svh
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH

// Command codes recognised by the handler.
`define FPC_OP_CFG_READ 8'h2B
`define FPC_OP_CFG_PROG 8'h2F
`define FPC_OP_STS_READ 8'hA7
`define FPC_OP_STS_LOCK 8'hA6
`define FPC_OP_WR_EN 8'h06

// Reset values and field positions.
`define FPC_CFG_RST 16'hFFFF
`define FPC_STS_RST 8'h01
`define FPC_LOCK_BIT 0
`define FPC_GUARD_BIT 6

// Last value of the bit counter for the opcode and data phases, single-bit and four-bit.
`define FPC_OPC_LAST_SIO 5'h07
`define FPC_OPC_LAST_QIO 5'h01
`define FPC_DAT_LAST_SIO 5'h0F
`define FPC_DAT_LAST_QIO 5'h03

// Self-timed operation length: least time, rounded up to clock cycles.
`define FPC_CLK_NS 50
`define FPC_T_PROG_NS 2000
`define FPC_PROG_CYC ((`FPC_T_PROG_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_CNT_W 8

// Number of pin signals passed through the synchroniser.
`define FPC_SYNC_W 6

`endif

//--- fpc_pkg.sv
package fpc_pkg;

  // Frame decoding states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPCODE = 3'b001,
    ST_DUMMY = 3'b010,
    ST_READ = 3'b011,
    ST_DATA = 3'b100,
    ST_ARMED = 3'b101,
    ST_IGNORE = 3'b110
  } fpc_state_t;

  // Operation waiting for, or running after, the chip select rise.
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_WRITE_ENABLE_CMD = 2'b01,
    OP_PROG = 2'b10,
    OP_LOCK = 2'b11
  } fpc_op_t;

endpackage

//--- fpc_sync2.sv
module fpc_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Asynchronous inputs and their synchronised copies.
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // Two stages; the first stage feeds only the second.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

//--- fpc_op_timer.sv
`include "fpc_params.svh"

module fpc_op_timer (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Start request and progress.
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  localparam logic [`FPC_CNT_W-1:0] LAST = `FPC_CNT_W'(`FPC_PROG_CYC - 1);

  logic [`FPC_CNT_W-1:0] count;

  // Counts the self-timed interval and pulses done for one cycle at its end.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      count <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        count <= LAST;
      end else if (busy_o) begin
        if (count == '0) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule

//--- fpc_cmd_handler.sv
`include "fpc_params.svh"

module fpc_cmd_handler
  import fpc_pkg::*;
(
  // Clock and resets.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sw_reset_i,
  // Serial link pins.
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  // Mode and array events.
  input wire logic quad_peripheral_mode_i,
  input wire logic prog_fail_i,
  input wire logic unlock_ok_i,
  input wire logic clear_status_i,
  // Status and register contents.
  output logic write_in_progress_o,
  output logic write_enable_latch_o,
  output logic program_error_o,
  output logic [15:0] prot_config_reg_o,
  output logic [7:0] prot_status_reg_o
);

  // Last counter value of an opcode or data phase in the current width.
  function automatic logic [4:0] last_cnt(input logic quad, input logic data);
    if (data) begin
      last_cnt = quad ? `FPC_DAT_LAST_QIO : `FPC_DAT_LAST_SIO;
    end else begin
      last_cnt = quad ? `FPC_OPC_LAST_QIO : `FPC_OPC_LAST_SIO;
    end
  endfunction

  // Shifts one bit or one nibble into the low end of the receive register.
  function automatic logic [15:0] shift_in(input logic quad, input logic [15:0] sh,
                                           input logic [3:0] pins);
    shift_in = quad ? {sh[11:0], pins} : {sh[14:0], pins[0]};
  endfunction

  logic [`FPC_SYNC_W-1:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic [3:0] io_s;
  logic sclk_d;
  logic cs_d;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic cs_fall;
  logic quad;
  fpc_state_t state;
  fpc_op_t arm_op;
  fpc_op_t cur_op;
  logic [4:0] cnt;
  logic [15:0] sh;
  logic [15:0] next_sh;
  logic [7:0] next_opc;
  logic rd_sts;
  logic [15:0] out_sh;
  logic drv;
  logic [15:0] pend_cfg;
  logic op_start;
  logic op_done;
  logic busy;
  logic timer_rst_n;
  logic write_enable_cmd_done;

  // Link pins come from another clock domain and pass two flip-flops first.
  // Select travels inverted, so cleared stages read as a deselected bus after reset.
  fpc_sync2 #(.W(`FPC_SYNC_W)) u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i({~cs_n_i, sclk_i, io_i}),
    .sync_o(pins_s)
  );

  assign cs_n_s = !pins_s[5];
  assign sclk_s = pins_s[4];
  assign io_s = pins_s[3:0];
  assign quad = quad_peripheral_mode_i;

  // Edge history; select idles high so a reset does not fake a frame start.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_d <= cs_n_s;
    end
  end

  assign sclk_rise = sclk_s && !sclk_d && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_d && !cs_n_s;
  assign cs_rise = cs_n_s && !cs_d;
  assign cs_fall = !cs_n_s && cs_d;
  assign next_sh = shift_in(quad, sh, io_s);
  assign next_opc = next_sh[7:0];

  // Frame decoder: opcode, dummy, read and program data phases.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || sw_reset_i) begin
      state <= ST_IDLE;
      arm_op <= OP_NONE;
      cnt <= 5'h00;
      sh <= 16'h0000;
      rd_sts <= 1'b0;
    end else if (cs_n_s) begin
      state <= ST_IDLE;
    end else if (cs_fall) begin
      state <= ST_OPCODE;
      arm_op <= OP_NONE;
      cnt <= 5'h00;
    end else if (sclk_rise) begin
      case (state)
        ST_OPCODE: begin
          sh <= next_sh;
          cnt <= cnt + 5'h01;
          if (cnt == last_cnt(quad, 1'b0)) begin
            cnt <= 5'h00;
            if (write_in_progress_o) begin
              state <= ST_IGNORE;
            end else if (next_opc == `FPC_OP_CFG_READ) begin
              state <= ST_DUMMY;
              rd_sts <= 1'b0;
            end else if (next_opc == `FPC_OP_STS_READ) begin
              state <= ST_DUMMY;
              rd_sts <= 1'b1;
            end else if (next_opc == `FPC_OP_WR_EN) begin
              state <= ST_ARMED;
              arm_op <= OP_WRITE_ENABLE_CMD;
            end else if (next_opc == `FPC_OP_CFG_PROG && write_enable_latch_o) begin
              state <= ST_DATA;
            end else if (next_opc == `FPC_OP_STS_LOCK && write_enable_latch_o) begin
              state <= ST_ARMED;
              arm_op <= OP_LOCK;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_DUMMY: begin
          state <= ST_READ;
        end
        ST_DATA: begin
          sh <= next_sh;
          cnt <= cnt + 5'h01;
          if (cnt == last_cnt(quad, 1'b1)) begin
            state <= ST_ARMED;
            arm_op <= OP_PROG;
          end
        end
        ST_ARMED: begin
          state <= ST_IGNORE;
        end
        default: begin
          state <= state;
        end
      endcase
    end
  end

  // Read shifter; rotation makes the contents repeat while clocks continue.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || sw_reset_i) begin
      out_sh <= 16'h0000;
      io_o <= 4'h0;
      drv <= 1'b0;
    end else if (cs_n_s) begin
      drv <= 1'b0;
    end else if (sclk_rise && state == ST_DUMMY) begin
      if (rd_sts) begin
        out_sh <= {prot_status_reg_o, prot_status_reg_o};
      end else begin
        out_sh <= {prot_config_reg_o[7:0], prot_config_reg_o[15:8]};
      end
    end else if (sclk_fall && state == ST_READ) begin
      drv <= 1'b1;
      if (quad) begin
        io_o <= out_sh[15:12];
        out_sh <= {out_sh[11:0], out_sh[15:12]};
      end else begin
        io_o <= {2'b00, out_sh[15], 1'b0};
        out_sh <= {out_sh[14:0], out_sh[15]};
      end
    end
  end

  // Only the output line is driven in single-bit mode, all four in quad mode.
  assign io_oe_o = drv ? (quad ? 4'hF : 4'h2) : 4'h0;

  // A command is carried out only if select rises exactly after its last bit.
  assign op_start = cs_rise && state == ST_ARMED &&
                    (arm_op == OP_PROG || arm_op == OP_LOCK);
  assign write_enable_cmd_done = cs_rise && state == ST_ARMED && arm_op == OP_WRITE_ENABLE_CMD;
  assign timer_rst_n = rst_n_i && !sw_reset_i;

  fpc_op_timer u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(timer_rst_n),
    .start_i(op_start),
    .busy_o(busy),
    .done_o(op_done)
  );

  // Captures what the running operation needs, since the link may move on.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || sw_reset_i) begin
      cur_op <= OP_NONE;
      pend_cfg <= 16'h0000;
    end else if (op_start) begin
      cur_op <= arm_op;
      pend_cfg <= {sh[7:0], sh[15:8]};
    end
  end

  // Write enable latch: set by its command, cleared when an operation ends.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || sw_reset_i) begin
      write_enable_latch_o <= 1'b0;
    end else if (op_done) begin
      write_enable_latch_o <= 1'b0;
    end else if (write_enable_cmd_done) begin
      write_enable_latch_o <= 1'b1;
    end
  end

  // Progress and error flags; a failed operation leaves progress set until cleared.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || sw_reset_i) begin
      write_in_progress_o <= 1'b0;
      program_error_o <= 1'b0;
    end else begin
      if (clear_status_i) begin
        program_error_o <= 1'b0;
        if (program_error_o) begin
          write_in_progress_o <= 1'b0;
        end
      end
      if (op_start) begin
        write_in_progress_o <= 1'b1;
      end else if (op_done && !prog_fail_i) begin
        write_in_progress_o <= 1'b0;
      end
      if (op_done && prog_fail_i) begin
        program_error_o <= 1'b1;
      end
    end
  end

  // Configuration register is non-volatile and survives a software reset.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prot_config_reg_o <= `FPC_CFG_RST;
    end else if (op_done && cur_op == OP_PROG && !prog_fail_i) begin
      prot_config_reg_o <= pend_cfg;
    end
  end

  // Status register; the lock bit returns to its reset value on hard reset or unlock, never on software reset.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prot_status_reg_o <= `FPC_STS_RST;
    end else if (sw_reset_i) begin
      prot_status_reg_o[7:1] <= 7'(`FPC_STS_RST >> 1);
      if (unlock_ok_i) begin
        prot_status_reg_o[`FPC_LOCK_BIT] <= 1'b1;
      end
    end else begin
      if (op_done && cur_op == OP_LOCK && !prog_fail_i) begin
        prot_status_reg_o[`FPC_LOCK_BIT] <= 1'b0;
        prot_status_reg_o[`FPC_GUARD_BIT] <= prot_config_reg_o[`FPC_GUARD_BIT];
      end
      if (unlock_ok_i) begin
        prot_status_reg_o[`FPC_LOCK_BIT] <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  wel_before_op_a: assert property (op_start |-> write_enable_latch_o)
    else $error("operation started without write enable latch");
  wip_on_start_a: assert property (op_start |=> write_in_progress_o [*8])
    else $error("progress flag not held after start");
  wel_cleared_a: assert property (op_done && !sw_reset_i |=> !write_enable_latch_o)
    else $error("write enable latch not cleared at operation end");
  lock_effect_a: assert property (op_done && cur_op == OP_LOCK && !prog_fail_i &&
      !unlock_ok_i && !sw_reset_i |=> !prot_status_reg_o[0] &&
      prot_status_reg_o[6] == $past(prot_config_reg_o[6]))
    else $error("lock did not update status bits");
  dummy_quiet_a: assert property (state == ST_DUMMY |-> io_oe_o == 4'h0)
    else $error("output driven during dummy cycle");
  out_on_fall_a: assert property (!$stable(io_o) && $past(rst_n_i) && !$past(sw_reset_i)
      |-> $past(sclk_fall))
    else $error("read data changed off a falling clock");
  sw_keeps_lock_a: assert property (sw_reset_i && !unlock_ok_i
      |=> prot_status_reg_o[0] == $past(prot_status_reg_o[0]))
    else $error("software reset changed lock bit");
  unlock_sets_a: assert property (unlock_ok_i |=> prot_status_reg_o[0])
    else $error("unlock did not set lock bit");
  reject_keeps_a: assert property (cs_rise && state == ST_IGNORE && !busy && !sw_reset_i &&
      !unlock_ok_i |=> $stable(prot_config_reg_o) && $stable(prot_status_reg_o) &&
      $stable(write_in_progress_o))
    else $error("rejected command changed state");
  fail_flags_a: assert property (op_done && prog_fail_i && !sw_reset_i
      |=> program_error_o && write_in_progress_o)
    else $error("failure not reported");
  op_length_a: assert property (op_start |-> ##[1:60] op_done)
    else $error("operation did not finish in time");

endmodule

//--- fpc_host_model.sv
module fpc_host_model (
  // Clock and mode.
  input wire logic mclk_i,
  input wire logic quad_i,
  // Link pins as seen on the wire.
  input wire logic [3:0] io_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus: select high, clock low in mode 0.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end

  // One frame: opcode and data bits out, one dummy clock when reading, then read bits.
  // Each clock is eight system cycles; sampling waits for the late answer.
  task automatic frame(input logic [23:0] wb, input int wbits, input int rbits,
                       output logic [31:0] rd);
    int s;
    int nw;
    int nd;
    int nr;
    s = quad_i ? 4 : 1;
    nw = wbits / s;
    nd = (rbits > 0) ? 1 : 0;
    nr = rbits / s;
    rd = '0;
    @(posedge mclk_i) cs_n_o <= 1'b0;
    for (int k = 0; k < nw + nd + nr; k++) begin
      // Data phase sends MSB first, low byte ahead of high byte.
      if (k < nw) begin
        io_o <= quad_i ? wb[23:20] : {~io_o[3:1], wb[23]};
        wb = wb << s;
      end else begin
        io_o <= ~io_o;
      end
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge mclk_i);
      if (k >= nw + nd) begin
        rd = quad_i ? {rd[27:0], io_i} : {rd[30:0], io_i[1]};
      end
      @(posedge mclk_i) sclk_o <= 1'b0;
    end
    // Select rises right after the last bit; released lines keep toggling.
    repeat (2) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    io_o <= ~io_o;
    repeat (6) @(posedge mclk_i);
  endtask
endmodule

//--- flash_protection_cmd_handler_bench.sv
module flash_protection_cmd_handler_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk, rst_n, sw_reset, quad, prog_fail, unlock_ok, clear_status;
  logic sclk, cs_n, write_in_progress, write_enable_latch, perr;
  logic [3:0] host_io, dev_io, dev_oe, io_w;
  logic [15:0] cfg;
  logic [7:0] sts;
  logic [31:0] rd;
  int num_errors;
  int cmp_count;

  // Each wire line follows whichever party enables it.
  assign io_w = (dev_oe & dev_io) | (~dev_oe & host_io);

  fpc_cmd_handler dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .sw_reset_i(sw_reset), .sclk_i(sclk),
    .cs_n_i(cs_n), .io_i(io_w), .io_o(dev_io), .io_oe_o(dev_oe),
    .quad_peripheral_mode_i(quad), .prog_fail_i(prog_fail), .unlock_ok_i(unlock_ok),
    .clear_status_i(clear_status), .write_in_progress_o(write_in_progress),
    .write_enable_latch_o(write_enable_latch), .program_error_o(perr),
    .prot_config_reg_o(cfg), .prot_status_reg_o(sts)
  );

  fpc_host_model host (
    .mclk_i(mclk), .quad_i(quad), .io_i(io_w), .sclk_o(sclk), .cs_n_o(cs_n),
    .io_o(host_io)
  );

  // System clock, 50 ns period.
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_flag(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask

  // Bounded wait on the progress flag; running out ends the run.
  task automatic wait_wip(input logic v, input int n);
    for (int i = 0; i < n && write_in_progress !== v; i++) @(posedge mclk);
    chk_flag("wip_wait", v, write_in_progress);
    if (write_in_progress !== v) conclude();
  endtask

  task automatic t_read_cfg(input logic [15:0] e);
    host.frame({8'h2B, 16'h0}, 8, 32, rd);
    chk_val("cfg_read", {2{e[7:0], e[15:8]}}, rd);
  endtask

  task automatic t_read_sts(input logic [7:0] e);
    wait_wip(1'b0, 100);
    host.frame({8'hA7, 16'h0}, 8, 16, rd);
    chk_val("sts_read", {16'h0, e, e}, rd);
  endtask

  task automatic t_write_enable_cmd;
    host.frame({8'h06, 16'h0}, 8, 0, rd);
    chk_flag("wel_set", 1'b1, write_enable_latch);
  endtask

  // Program is refused without the latch and leaves everything alone.
  task automatic t_prog_nowel;
    host.frame({8'h2F, 16'h1234}, 24, 0, rd);
    repeat (50) @(posedge mclk);
    chk_val("cfg_nowel", 32'h0000FFFF, {16'h0, cfg});
    chk_flag("wip_nowel", 1'b0, write_in_progress);
  endtask

  task automatic t_prog(input logic [15:0] d, input logic fail);
    logic [15:0] old;
    old = cfg;
    prog_fail <= fail;
    t_write_enable_cmd();
    host.frame({8'h2F, d[7:0], d[15:8]}, 24, 0, rd);
    wait_wip(1'b1, 10);
    if (!fail) begin
      wait_wip(1'b0, 100);
      chk_val("cfg_prog", {16'h0, d}, {16'h0, cfg});
      chk_flag("wel_prog", 1'b0, write_enable_latch);
    end else begin
      repeat (60) @(posedge mclk);
      chk_flag("perr_fail", 1'b1, perr);
      chk_flag("wip_fail", 1'b1, write_in_progress);
      chk_val("cfg_fail", {16'h0, old}, {16'h0, cfg});
      @(posedge mclk) clear_status <= 1'b1;
      @(posedge mclk) clear_status <= 1'b0;
      repeat (3) @(posedge mclk);
      chk_flag("perr_clr", 1'b0, perr);
      chk_flag("wip_clr", 1'b0, write_in_progress);
    end
    prog_fail <= 1'b0;
  endtask

  // Select rises after fifteen data bits: the program is discarded.
  task automatic t_prog_short;
    t_write_enable_cmd();
    host.frame({8'h2F, 16'h0000}, 23, 0, rd);
    repeat (60) @(posedge mclk);
    chk_val("cfg_short", 32'h00005A74, {16'h0, cfg});
    chk_flag("wip_short", 1'b0, write_in_progress);
  endtask

  // Lock is refused while the latch is clear, so it runs first after a finished program.
  task automatic t_lock;
    host.frame({8'hA6, 16'h0}, 8, 0, rd);
    repeat (60) @(posedge mclk);
    chk_val("sts_nowel", 32'h01, {24'h0, sts});
    t_write_enable_cmd();
    host.frame({8'hA6, 16'h0}, 9, 0, rd);
    repeat (60) @(posedge mclk);
    chk_val("sts_long", 32'h01, {24'h0, sts});
    t_write_enable_cmd();
    host.frame({8'hA6, 16'h0}, 8, 0, rd);
    wait_wip(1'b1, 10);
    wait_wip(1'b0, 100);
    chk_val("sts_lock", 32'h40, {24'h0, sts});
    chk_flag("wel_lock", 1'b0, write_enable_latch);
  endtask

  task automatic t_resets;
    @(posedge mclk) sw_reset <= 1'b1;
    @(posedge mclk) sw_reset <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_flag("lock_swrst", 1'b0, sts[0]);
    chk_val("cfg_swrst", 32'h00005A74, {16'h0, cfg});
    @(posedge mclk) unlock_ok <= 1'b1;
    @(posedge mclk) unlock_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_flag("lock_unlock", 1'b1, sts[0]);
  endtask

  // Main sequence; reset is held for twenty cycles.
  initial begin
    num_errors = 0;
    cmp_count = 0;
    {rst_n, sw_reset, quad, prog_fail, unlock_ok, clear_status} = 6'h00;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_val("cfg_rst", 32'h0000FFFF, {16'h0, cfg});
    chk_val("flags_rst", 32'h01, {21'h0, write_in_progress, write_enable_latch, perr, sts});
    t_read_cfg(16'hFFFF);
    t_read_sts(8'h01);
    t_prog_nowel();
    t_prog(16'h5A74, 1'b0);
    t_read_cfg(16'h5A74);
    t_lock();
    t_prog_short();
    t_read_sts(8'h40);
    t_resets();
    t_prog(16'h1111, 1'b1);
    quad <= 1'b1;
    @(posedge mclk);
    t_prog(16'hC3E1, 1'b0);
    t_read_cfg(16'hC3E1);
    conclude();
  end
endmodule
